/* File: rtl/hcg_map.svh */
// Register offsets, field positions, reset values and fixed counts of the hardware cursor generator.
// Assumes inclusion by bare name from the cursor package and modules; definitions only.
`ifndef HCG_MAP_SVH
`define HCG_MAP_SVH

// Register byte offsets, one aligned 32-bit word each
`define HCG_OFF_BASE      8'h00
`define HCG_OFF_POS       8'h04
`define HCG_OFF_COL0      8'h08
`define HCG_OFF_COL1      8'h0c
`define HCG_OFF_CFG       8'h10
`define HCG_OFF_STATUS    8'h14

// Field positions
`define HCG_BASE_MSB      23
`define HCG_POS_X_LSB     0
`define HCG_POS_Y_LSB     16
`define HCG_COORD_W       11
`define HCG_COL_MSB       23
`define HCG_CFG_MODE_BIT  1
`define HCG_CFG_EN_BIT    27

// Reset values
`define HCG_RST_REG       32'h0000_0000

// Cursor shape and fetch geometry
`define HCG_CUR_LAST      6'h3f
`define HCG_FETCH_LAST    3'h7
`define HCG_LINE_STRIDE   24'h00_0010

// AXI responses
`define HCG_RESP_OK       2'h0
`define HCG_RESP_ERR      2'h2

`endif

/* File: rtl/hcg_pkg.sv */
// Types and shared helper of the hardware cursor generator.
// Assumes hcg_map.svh is on the include path.
`include "hcg_map.svh"

package hcg_pkg;

   // Fetch engine states
   typedef enum logic [1:0] {
      HCG_IDLE,
      HCG_REQ,
      HCG_WAIT
   } hcg_fetch_st_t;

   // Where a screen coordinate falls inside the cursor span
   typedef struct packed {
      logic       hit;
      logic [5:0] idx;
   } hcg_span_t;

   // Cursor spans the 64 coordinates that end at pos; below zero is never reached
   function automatic hcg_span_t hcg_span(input logic [`HCG_COORD_W-1:0] coord,
                                          input logic [`HCG_COORD_W-1:0] pos);
      logic [`HCG_COORD_W-1:0] diff;
      hcg_span_t               s;
      diff  = pos - coord;
      s.hit = (coord <= pos) && (diff <= {5'h00, `HCG_CUR_LAST});
      s.idx = `HCG_CUR_LAST - diff[5:0];
      return s;
   endfunction

endpackage

/* File: rtl/hcg_pix_if.sv */
// Pixel path between the cursor top and its colour mapper.
// Assumes one clock; the mapper is purely combinational.
`timescale 1ns/1ps

interface hcg_pix_if;
   logic        hit;     // Pixel lies inside the cursor
   logic        bit0;    // Bit from bitmap zero
   logic        bit1;    // Bit from bitmap one
   logic        mode;    // 1 two-colour, 0 inverting
   logic [23:0] col0;    // Cursor colour zero
   logic [23:0] col1;    // Cursor colour one
   logic [23:0] screen;  // Final composed screen pixel
   logic [23:0] result;  // Pixel to display

   modport src (output hit, bit0, bit1, mode, col0, col1, screen, input result);
   modport map (input hit, bit0, bit1, mode, col0, col1, screen, output result);
endinterface

/* File: rtl/hcg_colour_map.sv */
// Colour mapper: picks cursor colour, screen colour or inverted screen colour per pixel.
// Assumes all inputs settle within the cycle; the caller registers the result.
`timescale 1ns/1ps

module hcg_colour_map (
   hcg_pix_if.map p
);

   // Mapping by mode and bit pair (bitmap0, bitmap1)
   always_comb begin
      if (!p.hit) begin
         p.result = p.screen;
      end else if (p.mode) begin
         case ({p.bit0, p.bit1})
            2'b10:   p.result = p.col0;
            2'b11:   p.result = p.col1;
            default: p.result = p.screen;
         endcase
      end else begin
         case ({p.bit0, p.bit1})
            2'b00:   p.result = p.col0;
            2'b01:   p.result = p.col1;
            2'b10:   p.result = p.screen;
            default: p.result = ~p.screen;
         endcase
      end
   end

endmodule

/* File: rtl/hcg_cursor.sv */
// Hardware cursor generator: AXI4-Lite registers, bitmap fetch engine and pixel overlay.
// Assumes one 200 MHz clock, a memory read port with one word in flight, and composed screen pixels.
// What this block does
// - Each 128-bit word: bitmap0 low, bitmap1 high
// - Test coverage each retrace, fetch only then
// - Fetch eight words: the aligned eight-line block holding the coming line
// - Linear addressing, 16-byte line stride from base
// - Inverting mode: c0, c1, screen, inverted screen
// - Two-colour mode: screen, screen, c0, c1
// - Base register holds 24-bit address
// - Position is bottom-right corner, 0 to 2047
// - X in 10:0, Y in 26:16
// - Colour zero: blue, green, red bytes
// - Colour one: same byte layout
// - Mode bit: one two-colour, zero inverting
// - Enable bit off: no fetch, no change
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "hcg_map.svh"

module hcg_cursor (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   input  wire logic         hretrace,
   input  wire logic [10:0]  line_y,
   output logic              mem_rd_valid,
   output logic [23:0]       mem_rd_addr,
   input  wire logic         mem_rd_ready,
   input  wire logic         mem_rdata_valid,
   input  wire logic [127:0] mem_rdata,
   input  wire logic         pix_in_valid,
   input  wire logic [10:0]  pix_x,
   input  wire logic [23:0]  pix_screen,
   output logic              pix_out_valid,
   output logic [23:0]       pix_out
);

   // Software registers
   logic [31:0] base_r;          // Bitmap base address
   logic [31:0] pos_r;           // Cursor corner
   logic [31:0] col0_r;          // Colour zero
   logic [31:0] col1_r;          // Colour one
   logic [31:0] cfg_r;           // Enable and mode
   // AXI slave state
   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic        aw_held_r, w_held_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic        commit;          // Both halves of a write present
   // Fetch engine
   hcg_pkg::hcg_fetch_st_t st_r;
   logic [127:0] line_ram [0:7]; // Eight cursor lines
   logic [2:0]   fetch_cnt_r;    // Word within the block
   logic [2:0]   fetch_blk_r;    // Block being fetched
   logic [2:0]   tag_r;          // Block held in the line RAM
   logic         tag_valid_r;
   logic         mem_rd_valid_r;
   logic [23:0]  mem_rd_addr_r;
   logic         need_fetch;
   logic         cfg_en, cfg_mode;
   hcg_pkg::hcg_span_t row_span, col_span;
   // Line state, caught at retrace
   logic         row_hit_r;
   logic [5:0]   row_idx_r;
   // Pixel pipeline
   logic         s1_valid_r, s1_hit_r, s1_b0_r, s1_b1_r;
   logic [23:0]  s1_screen_r;
   logic         pix_out_valid_r;
   logic [23:0]  pix_out_r;
   logic [127:0] cur_word;
   hcg_pix_if    pix ();

   assign cfg_en   = cfg_r[`HCG_CFG_EN_BIT];
   assign cfg_mode = cfg_r[`HCG_CFG_MODE_BIT];

   // Byte-lane merge of a register write
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Is a byte offset one of ours
   function automatic logic mapped(input logic [7:0] a, input logic wr);
      return (a == `HCG_OFF_BASE) || (a == `HCG_OFF_POS) || (a == `HCG_OFF_COL0) ||
             (a == `HCG_OFF_COL1) || (a == `HCG_OFF_CFG) || (!wr && a == `HCG_OFF_STATUS);
   endfunction

   assign commit = aw_held_r && w_held_r && !bvalid_r;

   // Write address and data channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         // Address half
         if (s_axi_awvalid && awready_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            awready_r <= 1'b0;
         end else if (commit) begin
            aw_held_r <= 1'b0;
         end else if (!aw_held_r && !bvalid_r) begin
            awready_r <= 1'b1;
         end
         // Data half
         if (s_axi_wvalid && wready_r) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            wready_r <= 1'b0;
         end else if (commit) begin
            w_held_r <= 1'b0;
         end else if (!w_held_r && !bvalid_r) begin
            wready_r <= 1'b1;
         end
      end
   end

   // Write response; unmapped offsets answer SLVERR and store nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `HCG_RESP_OK;
      end else if (commit) begin
         bvalid_r <= 1'b1;
         bresp_r  <= mapped(aw_addr_r, 1'b1) ? `HCG_RESP_OK : `HCG_RESP_ERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Register storage; position resets to zero but software must program it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_r <= `HCG_RST_REG;
         pos_r  <= `HCG_RST_REG;
         col0_r <= `HCG_RST_REG;
         col1_r <= `HCG_RST_REG;
         cfg_r  <= `HCG_RST_REG;
      end else if (commit) begin
         case (aw_addr_r)
            `HCG_OFF_BASE: base_r <= wmerge(base_r, w_data_r, w_strb_r) & 32'h00ff_ffff;
            `HCG_OFF_POS:  pos_r  <= wmerge(pos_r, w_data_r, w_strb_r) & 32'h07ff_07ff;
            `HCG_OFF_COL0: col0_r <= wmerge(col0_r, w_data_r, w_strb_r) & 32'h00ff_ffff;
            `HCG_OFF_COL1: col1_r <= wmerge(col1_r, w_data_r, w_strb_r) & 32'h00ff_ffff;
            `HCG_OFF_CFG:  cfg_r  <= wmerge(cfg_r, w_data_r, w_strb_r);
            default:       cfg_r  <= cfg_r;
         endcase
      end
   end

   // Read channel, answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= `HCG_RESP_OK;
      end else if (s_axi_arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= mapped(s_axi_araddr, 1'b0) ? `HCG_RESP_OK : `HCG_RESP_ERR;
         case (s_axi_araddr)
            `HCG_OFF_BASE:   rdata_r <= base_r;
            `HCG_OFF_POS:    rdata_r <= pos_r;
            `HCG_OFF_COL0:   rdata_r <= col0_r;
            `HCG_OFF_COL1:   rdata_r <= col1_r;
            `HCG_OFF_CFG:    rdata_r <= cfg_r;
            `HCG_OFF_STATUS: rdata_r <= {26'h000_0000, st_r != hcg_pkg::HCG_IDLE, tag_valid_r, 1'b0, tag_r};
            default:         rdata_r <= 32'h0000_0000;
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end else if (!rvalid_r) begin
         arready_r <= 1'b1;
      end
   end

   // Row of the coming scanline inside the cursor
   assign row_span   = hcg_pkg::hcg_span(line_y, pos_r[`HCG_POS_Y_LSB +: `HCG_COORD_W]);
   assign need_fetch = hretrace && cfg_en && row_span.hit &&
                       !(tag_valid_r && tag_r == row_span.idx[5:3]);

   // Line state latched at each retrace
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         row_hit_r <= 1'b0;
         row_idx_r <= 6'h00;
      end else if (hretrace) begin
         row_hit_r <= cfg_en && row_span.hit;
         row_idx_r <= row_span.idx;
      end
   end

   // Fetch engine: one aligned block of eight lines, one word in flight.
   // Buffer tag is claimed at start, so a retrace during the fetch does not restart it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r           <= hcg_pkg::HCG_IDLE;
         fetch_cnt_r    <= 3'h0;
         fetch_blk_r    <= 3'h0;
         tag_r          <= 3'h0;
         tag_valid_r    <= 1'b0;
         mem_rd_valid_r <= 1'b0;
         mem_rd_addr_r  <= 24'h00_0000;
      end else begin
         case (st_r)
            hcg_pkg::HCG_IDLE: begin
               if (need_fetch && st_r == hcg_pkg::HCG_IDLE) begin
                  st_r           <= hcg_pkg::HCG_REQ;
                  fetch_blk_r    <= row_span.idx[5:3];
                  fetch_cnt_r    <= 3'h0;
                  tag_r          <= row_span.idx[5:3];
                  tag_valid_r    <= 1'b1;
                  mem_rd_valid_r <= 1'b1;
                  mem_rd_addr_r  <= base_r[23:0] + {14'h0000, row_span.idx[5:3], 7'h00};
               end
            end
            hcg_pkg::HCG_REQ: begin
               if (mem_rd_ready) begin
                  mem_rd_valid_r <= 1'b0;
                  st_r           <= hcg_pkg::HCG_WAIT;
               end
            end
            hcg_pkg::HCG_WAIT: begin
               if (mem_rdata_valid) begin
                  fetch_cnt_r <= fetch_cnt_r + 3'h1;
                  if (fetch_cnt_r == `HCG_FETCH_LAST) begin
                     st_r <= hcg_pkg::HCG_IDLE;
                  end else begin
                     st_r           <= hcg_pkg::HCG_REQ;
                     mem_rd_valid_r <= 1'b1;
                     mem_rd_addr_r  <= mem_rd_addr_r + `HCG_LINE_STRIDE;
                  end
               end
            end
            default: st_r <= hcg_pkg::HCG_IDLE;
         endcase
         // Moving the cursor or its bitmap makes the held lines stale
         if (commit && (aw_addr_r == `HCG_OFF_BASE || aw_addr_r == `HCG_OFF_POS)) begin
            tag_valid_r <= 1'b0;
         end
      end
   end

   // Line RAM fill, indexed by line within the block
   always_ff @(posedge aclk) begin
      if (st_r == hcg_pkg::HCG_WAIT && mem_rdata_valid) begin
         line_ram[fetch_cnt_r] <= mem_rdata;
      end
   end

   // Pixel stage one: column lookup and bitmap bits
   assign col_span = hcg_pkg::hcg_span(pix_x, pos_r[`HCG_POS_X_LSB +: `HCG_COORD_W]);
   assign cur_word = line_ram[row_idx_r[2:0]];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_valid_r  <= 1'b0;
         s1_hit_r    <= 1'b0;
         s1_b0_r     <= 1'b0;
         s1_b1_r     <= 1'b0;
         s1_screen_r <= 24'h00_0000;
      end else begin
         s1_valid_r  <= pix_in_valid;
         s1_hit_r    <= pix_in_valid && cfg_en && row_hit_r && col_span.hit;
         s1_b0_r     <= cur_word[{1'b0, col_span.idx}];
         s1_b1_r     <= cur_word[{1'b1, col_span.idx}];
         s1_screen_r <= pix_screen;
      end
   end

   // Mapper inputs
   assign pix.hit    = s1_hit_r;
   assign pix.bit0   = s1_b0_r;
   assign pix.bit1   = s1_b1_r;
   assign pix.mode   = cfg_mode;
   assign pix.col0   = col0_r[`HCG_COL_MSB:0];
   assign pix.col1   = col1_r[`HCG_COL_MSB:0];
   assign pix.screen = s1_screen_r;

   hcg_colour_map u_map (
      .p (pix.map)
   );

   // Output pixel register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pix_out_valid_r <= 1'b0;
         pix_out_r       <= 24'h00_0000;
      end else begin
         pix_out_valid_r <= s1_valid_r;
         pix_out_r       <= pix.result;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign mem_rd_valid  = mem_rd_valid_r;
   assign mem_rd_addr   = mem_rd_addr_r;
   assign pix_out_valid = pix_out_valid_r;
   assign pix_out       = pix_out_r;

   // Request accepted then its word returned
   sequence word_req_s;
      mem_rd_valid_r && mem_rd_ready;
   endsequence
   sequence word_back_s;
      (st_r == hcg_pkg::HCG_WAIT) && mem_rdata_valid;
   endsequence

   fetch_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (need_fetch && st_r == hcg_pkg::HCG_IDLE) |=> mem_rd_valid_r) else $error("retrace hit gave no fetch");
   no_fetch_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_r == hcg_pkg::HCG_IDLE && !cfg_en) |=> !mem_rd_valid_r) else $error("fetch while disabled");
   addr_stride_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mem_rd_valid_r |-> mem_rd_addr_r == base_r[23:0] + {14'h0000, fetch_blk_r, fetch_cnt_r, 4'h0})
      else $error("bad bitmap line address");
   req_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
      word_req_s |=> (st_r == hcg_pkg::HCG_WAIT) && !mem_rd_valid_r) else $error("taken request not waiting");
   eight_words_a: assert property (@(posedge aclk) disable iff (!aresetn)
      word_back_s |-> ((fetch_cnt_r == `HCG_FETCH_LAST) ##1 (st_r == hcg_pkg::HCG_IDLE))
      or ((fetch_cnt_r != `HCG_FETCH_LAST) ##1 mem_rd_valid_r)) else $error("fetch length wrong");
   map_invert_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s1_hit_r && !cfg_mode && s1_b0_r && s1_b1_r) |=> pix_out_r == ~$past(s1_screen_r))
      else $error("inverting mode wrong");
   map_two_col_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s1_hit_r && cfg_mode && !s1_b0_r) |=> pix_out_r == $past(s1_screen_r)) else $error("two-colour screen wrong");
   colour_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s1_hit_r && s1_b0_r && s1_b1_r && cfg_mode) |=> pix_out_r == $past(col1_r[23:0])) else $error("colour one wrong");
   clip_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pix_in_valid && !col_span.hit) |=> ##1 pix_out_r == $past(pix_screen, 2)) else $error("outside pixel changed");

endmodule

/* File: tb/hcg_mem_model.sv */
// Frame-buffer memory model answering cursor bitmap fetches with a pattern built from the address.
// Assumes one request in flight; ready and data both come after random stalls.
`timescale 1ns/1ps

module hcg_mem_model (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         mem_rd_valid,
   input  wire logic [23:0]  mem_rd_addr,
   output logic              mem_rd_ready,
   output logic              mem_rdata_valid,
   output logic [127:0]      mem_rdata
);
   logic        pend_r;  // A taken request waits for its data
   logic [1:0]  dly_r;   // Cycles left before the data
   logic [23:0] addr_r;  // Address of the taken request

   // Acceptance, stall and answer; data toggles outside the pulse so stale words never look valid
   always @(posedge aclk) begin
      mem_rdata_valid <= 1'b0;
      mem_rdata       <= ~mem_rdata;
      if (!aresetn) begin
         mem_rd_ready <= 1'b0;
         pend_r       <= 1'b0;
         mem_rdata    <= 128'h0;
      end else if (pend_r) begin
         dly_r <= dly_r - 2'h1;
         if (dly_r == 2'h0) begin
            pend_r          <= 1'b0;
            mem_rdata_valid <= 1'b1;
            // Bitmap one high, zero low; row and block parity flip the halves
            mem_rdata <= {{16{4'ha}} ^ {64{addr_r[7]}}, {16{4'hc}} ^ {64{addr_r[4]}}};
         end
      end else if (mem_rd_valid && mem_rd_ready) begin
         mem_rd_ready <= 1'b0;
         pend_r       <= 1'b1;
         addr_r       <= mem_rd_addr;
         dly_r        <= 2'($urandom);
      end else begin
         // Ready only sometimes, to stall the fetch engine
         mem_rd_ready <= mem_rd_valid && ($urandom % 2 == 0);
      end
   end
endmodule

/* File: tb/test_hardware_cursor_generator.sv */
// Self-checking bench of the cursor generator: registers, bitmap fetches and pixel overlay.
// Assumes the memory model answers every fetch; expectations are built here.
`timescale 1ns/1ps
`include "hcg_map.svh"

module test_hardware_cursor_generator;
   logic         aclk, aresetn, hretrace, pix_in_valid, pix_out_valid;
   logic [7:0]   s_axi_awaddr, s_axi_araddr;
   logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0]  s_axi_wdata, s_axi_rdata, d;
   logic [3:0]   s_axi_wstrb;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   logic         mem_rd_valid, mem_rd_ready, mem_rdata_valid;
   logic [10:0]  line_y, pix_x, px, py;   // Pixel inputs; shadow cursor corner
   logic [23:0]  mem_rd_addr, pix_screen, pix_out, base, c0, c1;
   logic [127:0] mem_rdata;
   logic [63:0]  rq[$], bq[$], aq[$], pq[$];   // Expected results, oldest first
   logic         en, mode, rowhit;              // Shadow config and latched row state
   logic [5:0]   row;
   logic [10:0]  ys [0:5];                      // Scanlines of each sweep
   int           error_cnt, tests_run, words, blk;   // blk: block held on chip, -1 none

   // Free-running 200 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   hcg_cursor u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .hretrace, .line_y, .mem_rd_valid, .mem_rd_addr, .mem_rd_ready, .mem_rdata_valid,
      .mem_rdata, .pix_in_valid, .pix_x, .pix_screen, .pix_out_valid, .pix_out);
   hcg_mem_model u_mem (.aclk, .aresetn, .mem_rd_valid, .mem_rd_addr, .mem_rd_ready, .mem_rdata_valid,
      .mem_rdata);

   // Single comparison point
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Result with no note pending is a mismatch
   task automatic take(ref logic [63:0] q[$], input logic [63:0] seen);
      if (q.size() == 0) chk(seen, ~seen);
      else chk(seen, q.pop_front());
   endtask

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Write; readies sampled at the edge, bready held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] r);
      bq.push_back(64'(r));
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= v;
      s_axi_wstrb   <= s;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask

   // Read; expected {rresp, rdata} noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(64'(e));
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask

   // Output watcher: each result takes the oldest note of its kind
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) take(rq, {30'h0, s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) take(bq, {62'h0, s_axi_bresp});
      if (mem_rd_valid === 1'b1 && mem_rd_ready === 1'b1) take(aq, {40'h0, mem_rd_addr});
      if (mem_rdata_valid === 1'b1) words++;
      if (pix_out_valid === 1'b1) take(pq, {40'h0, pix_out});
   end

   // Expected pixel; column 0 is the leftmost, model flips bitmaps by row and block parity
   function automatic logic [23:0] exp_pix(input logic [10:0] x, input logic [23:0] scr);
      logic [11:0] c;
      c = {1'b0, x} + 12'h03f - {1'b0, px};
      if (!(rowhit && c <= 12'h03f)) return scr;
      case ({mode, c[1] ^ row[0], c[0] ^ row[3]})
         3'b000: return c0;
         3'b001: return c1;
         3'b011: return ~scr;
         3'b110: return c0;
         3'b111: return c1;
         default: return scr;
      endcase
   endfunction

   // One scanline: retrace, fetch when a new block is due, then a pixel sweep over columns 0 to 129
   task automatic line(input logic [10:0] y);
      logic [11:0] r;
      logic [23:0] s;
      logic        fetch;
      int          n;
      r      = {1'b0, y} + 12'h03f - {1'b0, py};
      rowhit = en && r <= 12'h03f;
      row    = r[5:0];
      fetch  = rowhit && blk != int'(row[5:3]);
      words  = 0;
      if (fetch) begin
         for (int i = 0; i < 8; i++) aq.push_back(64'(base + 24'(128 * row[5:3] + 16 * i)));
         blk = row[5:3];
      end
      @(posedge aclk);
      hretrace <= 1'b1;
      line_y   <= y;
      @(posedge aclk);
      hretrace <= 1'b0;
      n = 0;
      while (fetch && words < 8 && n < 400) begin
         @(posedge aclk);
         n++;
      end
      repeat (4) @(posedge aclk);
      chk(64'(words), fetch ? 64'h8 : 64'h0);
      for (int x = 0; x < 130; x++) begin
         s = 24'($urandom);
         pq.push_back(64'(exp_pix(11'(x), s)));
         @(posedge aclk);
         pix_in_valid <= 1'b1;
         pix_x        <= 11'(x);
         pix_screen   <= s;
      end
      @(posedge aclk);
      pix_in_valid <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask

   // Main sequence
   initial begin
      void'($urandom(97));
      {aresetn, hretrace, pix_in_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 22'h0;
      {s_axi_wdata, line_y, pix_x, pix_screen} = 78'h0;
      {error_cnt, tests_run, words, blk} = {32'h0, 32'h0, 32'h0, 32'hffffffff};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, then the unmapped word
      for (int i = 0; i < 7; i++) rd(8'(4 * i), {(i == 6) ? 2'h2 : 2'h0, 32'h0});
      for (int i = 0; i < 5; i++) begin
         d = $urandom;
         wr(8'(4 * i), d, 4'hf, 2'h0);
         rd(8'(4 * i), {2'h0, d & ((i == 1) ? 32'h07ff07ff : (i == 4) ? 32'hffffffff : 32'h00ffffff)});
      end
      wr(8'h18, d, 4'hf, 2'h2);
      wr(`HCG_OFF_COL1, 32'h0, 4'hf, 2'h0);
      wr(`HCG_OFF_COL1, 32'hffffffff, 4'h2, 2'h0);
      rd(`HCG_OFF_COL1, {2'h0, 32'h0000ff00});
      // Cursor clipped on the left edge
      base = 24'h012300;
      px   = 11'h028;
      py   = 11'h064;
      c0   = 24'($urandom);
      c1   = 24'($urandom);
      wr(`HCG_OFF_BASE, {8'h0, base}, 4'hf, 2'h0);
      wr(`HCG_OFF_POS, {5'h0, py, 5'h0, px}, 4'hf, 2'h0);
      wr(`HCG_OFF_COL0, {8'h0, c0}, 4'hf, 2'h0);
      wr(`HCG_OFF_COL1, {8'h0, c1}, 4'hf, 2'h0);
      blk = -1;
      ys  = '{11'd36, 11'd37, 11'd44, 11'd45, 11'd100, 11'd101};
      // Inverting, two-colour, then disabled
      for (int k = 0; k < 3; k++) begin
         en   = k < 2;
         mode = k > 0;
         wr(`HCG_OFF_CFG, {4'h0, en, 25'h0, mode, 1'b0}, 4'hf, 2'h0);
         foreach (ys[j]) line(ys[j]);
      end
      rd(`HCG_OFF_STATUS, {2'h0, 32'h00000017});
      repeat (10) @(posedge aclk);
      chk(64'(rq.size() + bq.size() + aq.size() + pq.size()), 64'h0);
      end_of_test;
   end

   // Hang guard
   initial begin
      #100us;
      error_cnt++;
      end_of_test;
   end
endmodule
